// ===== rtl/dasc_pkg.sv
// dasc_pkg: constants and types for the diagnostic adc sequencer control
// assumes a 100 MHz system clock and 16-bit registers on a wishbone bus
package dasc_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned ADC_CLK_HZ   = 76_800;
  // one adc clock in system cycles, rounded down
  localparam int unsigned ADC_TICK_CYC = CLK_HZ / ADC_CLK_HZ;
  localparam int unsigned TICK_W       = 12;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_SWRST = 6'h07;
  localparam logic [5:0] IDX_CFG   = 6'h08;
  localparam logic [5:0] IDX_SEQ   = 6'h09;
  localparam logic [5:0] IDX_TRIG  = 6'h0a;
  localparam logic [5:0] IDX_SPEC  = 6'h0b;

  localparam logic [15:0] RST_CFG  = 16'h8810;
  localparam logic [7:0]  RST_SEQ  = 8'h80;
  localparam logic [7:0]  SWRST_KEY = 8'had;

  localparam int unsigned TRIG_ADC    = 0;
  localparam int unsigned TRIG_RELOAD = 1;
  localparam int unsigned SPEC_PINEN  = 0;
  localparam int unsigned SPEC_POL    = 1;
  localparam int unsigned SPEC_RELOAD = 2;

  // slot lengths in adc clocks for each rate code
  localparam logic [6:0] SLOT_R0    = 7'(ADC_CLK_HZ / 3840);
  localparam logic [6:0] SLOT_R1    = 7'(ADC_CLK_HZ / 2560);
  localparam logic [6:0] SLOT_R2    = 7'(ADC_CLK_HZ / 1280);
  localparam logic [6:0] SLOT_R3    = 7'(ADC_CLK_HZ / 640);
  localparam logic [6:0] SLOT_OTHER = 7'(ADC_CLK_HZ / 2560);

  localparam logic [3:0] CH_OFFSET = 4'h0;
  localparam logic [3:0] CH_ANALOG_INPUT_ZERO   = 4'h1;
  localparam logic [3:0] CH_ANALOG_INPUT_ONE   = 4'h2;
  localparam logic [3:0] CH_TEMP   = 4'h3;
  localparam logic [3:0] CH_GND    = 4'h9;

  localparam logic [3:0] THR_HI_FILL = 4'hf;
  localparam logic [3:0] THR_LO_FILL = 4'h0;
  localparam logic [1:0] ACT_ALARM_V = 2'h2;

  // field order matches the configuration register bit layout
  typedef struct packed {
    logic       inputBufferOff;
    logic [6:0] thresholdHysteresisCodes;
    logic [2:0] consecutiveFaultLimit;
    logic       inputSpanSelect;
    logic       convDoneEachChannel;
    logic [1:0] sampleRateSelect;
    logic       directMode;
  } dasc_cfg_t;

  typedef struct packed {
    logic [3:0] stopIdx;
    logic [3:0] startIdx;
  } dasc_seq_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } dasc_state_t;
endpackage

// ===== rtl/dasc_top.sv
// dasc_top: register file, channel sequencer, fault trip and alarm level
// assumes a wishbone classic master and an adc core on clk_sys
`timescale 1ns/100ps
`default_nettype none
module dasc_top #(
  parameter int unsigned TICK_CYCLES = dasc_pkg::ADC_TICK_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 sharedPolarityInputPin,
  input  wire logic [11:0]          adcResult,
  input  wire logic [1:0][15:0]     ainThreshold,
  input  wire logic [1:0][1:0]      ainAction,
  output dasc_pkg::dasc_cfg_t       adcCfg,
  output logic [3:0]                adcChannelSel,
  output logic                      adcBusy,
  output logic                      convDone,
  output logic                      sharedPinAsInput,
  output logic                      softResetPulse,
  output logic                      trimReloadPulse,
  output logic [1:0]                faultAlarm,
  output logic                      alarmLevelInternal,
  output logic                      driveAlarmLevel
);
  logic [1:0] rstSync_q;
  logic       rstInt_n;
  logic       pinMeta_q;
  logic       pinSync_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstInt_n = rstSync_q[1];

  always_ff @(posedge clk_sys or negedge rstInt_n) begin
    if (!rstInt_n) begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
    end else begin
      pinMeta_q <= sharedPolarityInputPin;
      pinSync_q <= pinMeta_q;
    end
  end

  // register file and bus slave
  dasc_pkg::dasc_cfg_t cfg_q, cfg_d;
  dasc_pkg::dasc_seq_t seq_q, seq_d;
  logic [2:0]  spec_q, spec_d;
  logic        adcTrig_q, adcTrig_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic        swRst_q, swRst_d;
  logic        reload_q, reload_d;
  logic        hwClrTrig;
  logic        wrEn, rdEn, keyWrite, trigWrite;
  logic [5:0]  regIdx;
  logic [15:0] wdat, rval;

  function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                             input logic [15:0] nw,
                                             input logic [1:0]  sel);
    mergeBytes = {sel[1] ? nw[15:8] : old[15:8],
                  sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  assign regIdx    = wb_adr_i[7:2];
  assign wdat      = wb_dat_i[15:0];
  assign wrEn      = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign rdEn      = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
  assign keyWrite  = wrEn && regIdx == dasc_pkg::IDX_SWRST && wb_sel_i[0]
                     && wdat[7:0] == dasc_pkg::SWRST_KEY;
  assign trigWrite = wrEn && regIdx == dasc_pkg::IDX_TRIG && wb_sel_i[0];

  always_comb begin
    cfg_d     = cfg_q;
    seq_d     = seq_q;
    spec_d    = spec_q;
    adcTrig_d = adcTrig_q;
    ack_d     = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d    = 32'h0;
    swRst_d   = keyWrite;
    // reload bit taken before the soft reset clears it
    reload_d  = (trigWrite && wdat[dasc_pkg::TRIG_RELOAD])
                || (keyWrite && spec_q[dasc_pkg::SPEC_RELOAD]);
    // hardware end-of-sequence clear loses to a software write
    if (hwClrTrig) begin
      adcTrig_d = 1'b0;
    end
    if (keyWrite) begin
      cfg_d     = dasc_pkg::RST_CFG;
      seq_d     = dasc_pkg::RST_SEQ;
      spec_d    = 3'h0;
      adcTrig_d = 1'b0;
    end else if (wrEn) begin
      unique case (regIdx)
        dasc_pkg::IDX_CFG: begin
          cfg_d = mergeBytes(cfg_q, wdat, wb_sel_i[1:0]);
        end
        dasc_pkg::IDX_SEQ: begin
          if (wb_sel_i[0]) begin
            seq_d = wdat[7:0];
          end
        end
        dasc_pkg::IDX_TRIG: begin
          if (wb_sel_i[0]) begin
            adcTrig_d = wdat[dasc_pkg::TRIG_ADC];
          end
        end
        dasc_pkg::IDX_SPEC: begin
          if (wb_sel_i[0]) begin
            spec_d = wdat[2:0];
          end
        end
        default: begin
        end
      endcase
    end
    rval = 16'h0;
    unique case (regIdx)
      dasc_pkg::IDX_CFG:  rval = cfg_q;
      dasc_pkg::IDX_SEQ:  rval = {8'h00, seq_q};
      dasc_pkg::IDX_TRIG: rval = {15'h0000, adcTrig_q};
      dasc_pkg::IDX_SPEC: rval = {13'h0000, spec_q};
      default:            rval = 16'h0;
    endcase
    if (rdEn) begin
      rdat_d = {16'h0000, rval};
    end
  end

  always_ff @(posedge clk_sys or negedge rstInt_n) begin
    if (!rstInt_n) begin
      cfg_q     <= dasc_pkg::RST_CFG;
      seq_q     <= dasc_pkg::RST_SEQ;
      spec_q    <= 3'h0;
      adcTrig_q <= 1'b0;
      ack_q     <= 1'b0;
      rdat_q    <= 32'h0;
      swRst_q   <= 1'b0;
      reload_q  <= 1'b0;
    end else begin
      cfg_q     <= cfg_d;
      seq_q     <= seq_d;
      spec_q    <= spec_d;
      adcTrig_q <= adcTrig_d;
      ack_q     <= ack_d;
      rdat_q    <= rdat_d;
      swRst_q   <= swRst_d;
      reload_q  <= reload_d;
    end
  end

  assign wb_ack_o         = ack_q;
  assign wb_dat_o         = rdat_q;
  assign adcCfg           = cfg_q;
  assign softResetPulse   = swRst_q;
  assign trimReloadPulse  = reload_q;
  assign sharedPinAsInput = spec_q[dasc_pkg::SPEC_PINEN];

  // channel sequencer
  localparam int unsigned TICK_W = dasc_pkg::TICK_W;
  dasc_pkg::dasc_state_t state_q, state_d;
  logic [TICK_W-1:0] tickCnt_q, tickCnt_d;
  logic [6:0]        slotCnt_q, slotCnt_d, slotLen;
  logic [3:0]        seqIdx_q, seqIdx_d, effStop, chanSel_d, chanSel_q;
  logic              tick, slotEnd, lastSlot, eoc_q, eoc_d;

  assign effStop = (seq_q.stopIdx < seq_q.startIdx) ? seq_q.startIdx
                                                    : seq_q.stopIdx;
  assign tick = tickCnt_q == TICK_W'(TICK_CYCLES - 1);

  always_comb begin
    state_d   = state_q;
    seqIdx_d  = seqIdx_q;
    slotCnt_d = slotCnt_q;
    tickCnt_d = tick ? '0 : tickCnt_q + 1'b1;
    slotEnd   = 1'b0;
    lastSlot  = seqIdx_q == effStop;
    hwClrTrig = 1'b0;
    // only the two external inputs follow the rate field
    if (seqIdx_q == dasc_pkg::CH_ANALOG_INPUT_ZERO || seqIdx_q == dasc_pkg::CH_ANALOG_INPUT_ONE) begin
      unique case (cfg_q.sampleRateSelect)
        2'h0: slotLen = dasc_pkg::SLOT_R0;
        2'h1: slotLen = dasc_pkg::SLOT_R1;
        2'h2: slotLen = dasc_pkg::SLOT_R2;
        2'h3: slotLen = dasc_pkg::SLOT_R3;
      endcase
    end else begin
      slotLen = dasc_pkg::SLOT_OTHER;
    end
    unique case (state_q)
      dasc_pkg::ST_IDLE: begin
        if (adcTrig_q) begin
          state_d   = dasc_pkg::ST_CONV;
          seqIdx_d  = seq_q.startIdx;
          slotCnt_d = 7'h0;
        end
      end
      dasc_pkg::ST_CONV: begin
        if (!adcTrig_q) begin
          state_d = dasc_pkg::ST_IDLE;
        end else if (tick) begin
          slotCnt_d = slotCnt_q + 7'h1;
          if (slotCnt_q + 7'h1 >= slotLen) begin
            slotEnd   = 1'b1;
            slotCnt_d = 7'h0;
            if (lastSlot) begin
              seqIdx_d = seq_q.startIdx;
              if (cfg_q.directMode) begin
                hwClrTrig = 1'b1;
                state_d   = dasc_pkg::ST_IDLE;
              end
            end else begin
              seqIdx_d = seqIdx_q + 4'h1;
            end
          end
        end
      end
      default: begin
        state_d = dasc_pkg::ST_IDLE;
      end
    endcase
    eoc_d = slotEnd && (cfg_q.convDoneEachChannel || lastSlot);
    // second input reads ground while its pin sets polarity
    chanSel_d = (seqIdx_d > 4'h8) ? dasc_pkg::CH_GND : seqIdx_d;
    if (seqIdx_d == dasc_pkg::CH_ANALOG_INPUT_ONE && !sharedPinAsInput) begin
      chanSel_d = dasc_pkg::CH_GND;
    end
  end

  always_ff @(posedge clk_sys or negedge rstInt_n) begin
    if (!rstInt_n) begin
      state_q   <= dasc_pkg::ST_IDLE;
      tickCnt_q <= '0;
      slotCnt_q <= 7'h0;
      seqIdx_q  <= 4'h0;
      chanSel_q <= 4'h0;
      eoc_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      tickCnt_q <= tickCnt_d;
      slotCnt_q <= slotCnt_d;
      seqIdx_q  <= seqIdx_d;
      chanSel_q <= chanSel_d;
      eoc_q     <= eoc_d;
    end
  end

  assign adcChannelSel = chanSel_q;
  assign adcBusy       = state_q == dasc_pkg::ST_CONV;
  assign convDone      = eoc_q;

  // fault detection on the two external inputs
  logic [1:0] alarmDrive;

  for (genvar c = 0; c < 2; c++) begin : g_fault
    logic [3:0]  cnt_q, cnt_d;
    logic        alarm_q, alarm_d, sample, fault;
    logic [12:0] hiThr, loThr;

    assign sample = slotEnd && seqIdx_q == dasc_pkg::CH_ANALOG_INPUT_ZERO + 4'(c)
                    && (c == 0 || sharedPinAsInput);
    assign hiThr = {1'b0, ainThreshold[c][15:8], dasc_pkg::THR_HI_FILL};
    assign loThr = {1'b0, ainThreshold[c][7:0], dasc_pkg::THR_LO_FILL};
    assign fault = {1'b0, adcResult} > hiThr
                   || {1'b0, adcResult} < loThr;

    always_comb begin
      cnt_d   = cnt_q;
      alarm_d = alarm_q;
      if (sample) begin
        cnt_d = fault ? cnt_q + 4'h1 : 4'h0;
        if (cnt_d > {1'b0, cfg_q.consecutiveFaultLimit}) begin
          alarm_d = 1'b1;
          cnt_d   = cnt_q;
        end
        // release only once back inside by the hysteresis margin
        if (alarm_q && {1'b0, adcResult} + 13'(cfg_q.thresholdHysteresisCodes)
            <= hiThr && {1'b0, adcResult} >=
            loThr + 13'(cfg_q.thresholdHysteresisCodes)) begin
          alarm_d = 1'b0;
          cnt_d   = 4'h0;
        end
      end
    end

    always_ff @(posedge clk_sys or negedge rstInt_n) begin
      if (!rstInt_n) begin
        cnt_q   <= 4'h0;
        alarm_q <= 1'b0;
      end else begin
        cnt_q   <= cnt_d;
        alarm_q <= alarm_d;
      end
    end

    assign faultAlarm[c] = alarm_q;
    assign alarmDrive[c] = alarm_q && ainAction[c] == dasc_pkg::ACT_ALARM_V;

    a_trip_count: assert property (@(posedge clk_sys) disable iff (!rstInt_n)
      $rose(alarm_q) |-> $past(sample) && $past(fault)
      && $past(cnt_q) == 4'($past(cfg_q.consecutiveFaultLimit)))
      else $error("alarm tripped at wrong fault count");
  end

  // alarm voltage level
  logic lvl_q, lvl_d, drive_q, drive_d;

  always_comb begin
    lvl_d   = spec_q[dasc_pkg::SPEC_POL]
              || (pinSync_q && !sharedPinAsInput);
    drive_d = |alarmDrive;
  end

  // drive flag resets high so the level holds during hardware reset
  always_ff @(posedge clk_sys or negedge rstInt_n) begin
    if (!rstInt_n) begin
      lvl_q   <= 1'b0;
      drive_q <= 1'b1;
    end else begin
      lvl_q   <= lvl_d;
      drive_q <= drive_d;
    end
  end

  assign alarmLevelInternal = lvl_q;
  assign driveAlarmLevel    = drive_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstInt_n);

  a_swreset_key: assert property (keyWrite |=> softResetPulse
    ##1 !softResetPulse && !wb_dat_o[0])
    else $error("soft reset key did not pulse once");
  a_swreset_read: assert property (rdEn && regIdx == dasc_pkg::IDX_SWRST
    |=> wb_ack_o && wb_dat_o == 32'h0)
    else $error("reset field read back nonzero");
  a_stop_forced: assert property (adcBusy |-> seqIdx_q <= effStop
    && seqIdx_q >= seq_q.startIdx)
    else $error("sequencer index outside start and stop");
  a_idx_step: assert property (slotEnd && !lastSlot
    |=> seqIdx_q == $past(seqIdx_q) + 4'h1)
    else $error("sequencer skipped an index");
  a_eoc_cause: assert property (convDone |-> $past(slotEnd)
    && ($past(cfg_q.convDoneEachChannel) || $past(lastSlot)))
    else $error("done pulse without matching slot end");
  a_direct_clear: assert property (slotEnd && lastSlot && cfg_q.directMode
    && !trigWrite && !keyWrite |=> !adcTrig_q && !adcBusy)
    else $error("direct sequence did not clear trigger");
  a_abort_seq: assert property (adcBusy && !adcTrig_q |=> !adcBusy
    ##1 !adcBusy || adcTrig_q)
    else $error("cleared trigger did not abort sequence");
  a_reload_pulse: assert property (trigWrite && wdat[dasc_pkg::TRIG_RELOAD]
    |=> trimReloadPulse ##1 !trimReloadPulse)
    else $error("reload trigger did not pulse once");
  a_reload_swrst: assert property (keyWrite |=> trimReloadPulse
    == $past(spec_q[dasc_pkg::SPEC_RELOAD]))
    else $error("soft reset reload did not follow its bit");
  a_alarm_level: assert property (##1 alarmLevelInternal ==
    ($past(spec_q[dasc_pkg::SPEC_POL]) || ($past(pinSync_q)
    && !$past(sharedPinAsInput))))
    else $error("alarm level mismatch");
  a_gnd_analog_input_one: assert property (adcBusy && seqIdx_q == dasc_pkg::CH_ANALOG_INPUT_ONE
    && $past(seqIdx_q) == seqIdx_q && !sharedPinAsInput && !$past(keyWrite)
    && $stable(sharedPinAsInput)
    |-> adcChannelSel == dasc_pkg::CH_GND)
    else $error("second input not grounded");

  c_direct_pass: cover property (cfg_q.directMode && slotEnd && lastSlot);
  c_auto_wrap: cover property (!cfg_q.directMode && slotEnd && lastSlot
    ##1 adcBusy);
  c_alarm_trip: cover property ($rose(faultAlarm[0]));
  c_abort: cover property (adcBusy && !adcTrig_q);
endmodule
`default_nettype wire

// ===== tb/dasc_top_tb.sv
// dasc_top_tb: self-checking bench for the adc sequencer control block
// assumes dasc_top with wishbone classic slave, one ack per request
`timescale 1ns/100ps
`default_nettype none
module dasc_top_tb;
  // short adc clock keeps slot waits small
  localparam int TICK = 2;
  localparam logic [7:0] A_RST  = {dasc_pkg::IDX_SWRST, 2'b00};
  localparam logic [7:0] A_CFG  = {dasc_pkg::IDX_CFG, 2'b00};
  localparam logic [7:0] A_SEQ  = {dasc_pkg::IDX_SEQ, 2'b00};
  localparam logic [7:0] A_TRIG = {dasc_pkg::IDX_TRIG, 2'b00};
  localparam logic [7:0] A_SPEC = {dasc_pkg::IDX_SPEC, 2'b00};

  logic                clk_sys, rst_n, wbCyc, wbStb, wbWe, wbAck;
  logic [7:0]          wbAdr;
  logic [3:0]          wbSel, chanSel;
  logic [31:0]         wbDatI, wbDatO;
  logic                sharedPin, adcBusy, convDone, pinAsInput;
  logic                srPulse, reloadPulse, alarmLevel, driveLevel;
  logic [11:0]         adcResult;
  logic [1:0][15:0]    ainThreshold;
  logic [1:0][1:0]     ainAction;
  logic [1:0]          faultAlarm;
  logic [15:0]         rdq;
  dasc_pkg::dasc_cfg_t adcCfg;
  int                  numErrors, checksDone, doneCnt, srCnt, reloadCnt, n;
  logic [3:0]          chSeq[$];

  dasc_top #(.TICK_CYCLES(TICK)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .sharedPolarityInputPin(sharedPin),
    .adcResult(adcResult), .ainThreshold(ainThreshold),
    .ainAction(ainAction), .adcCfg(adcCfg), .adcChannelSel(chanSel),
    .adcBusy(adcBusy), .convDone(convDone), .sharedPinAsInput(pinAsInput),
    .softResetPulse(srPulse), .trimReloadPulse(reloadPulse),
    .faultAlarm(faultAlarm), .alarmLevelInternal(alarmLevel),
    .driveAlarmLevel(driveLevel));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // pulse counters and the order of channels seen while busy
  always @(posedge clk_sys) begin
    if (convDone === 1'b1) doneCnt++;
    if (srPulse === 1'b1) srCnt++;
    if (reloadPulse === 1'b1) reloadCnt++;
    if (adcBusy === 1'b1 && (chSeq.size() == 0 || chSeq[$] !== chanSel))
      chSeq.push_back(chanSel);
  end

  task automatic tally_and_finish;
    if (numErrors == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      numErrors++;
    end
  endtask

  // a wait that ran out of cycles ends the run
  task automatic bail(input logic stuck);
    if (stuck) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      numErrors++;
      tally_and_finish();
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] a,
                         input logic [15:0] d, output logic [15:0] q);
    int k;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= {16'h0000, d};
    wbSel <= 4'h3;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wbAck !== 1'b1 && k < 50);
    bail(wbAck !== 1'b1);
    q = wbDatO[15:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    wb_xfer(1'b0, a, 16'h0000, q);
    chk({16'h0000, q}, {16'h0000, exp});
  endtask

  task automatic wait_done(output int k);
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (convDone !== 1'b1 && k < 2000);
    bail(convDone !== 1'b1);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (adcBusy !== 1'b0 && k < 3000);
    bail(adcBusy !== 1'b0);
  endtask

  // one direct-mode pass, checking pulses, channel order and self-clear
  task automatic run_pass(input logic [15:0] cfg, input logic [7:0] seq,
                          input int expDone, input logic [3:0] expCh[$]);
    wr(A_CFG, cfg);
    wr(A_SEQ, {8'h00, seq});
    doneCnt = 0;
    chSeq.delete();
    wr(A_TRIG, 16'h0001);
    wait_idle();
    repeat (2) @(posedge clk_sys);
    chk(32'(doneCnt), 32'(expDone));
    chk(32'(chSeq.size()), 32'(expCh.size()));
    foreach (expCh[i])
      if (i < chSeq.size()) chk(32'(chSeq[i]), 32'(expCh[i]));
    rd_chk(A_TRIG, 16'h0000);
  endtask

  logic [7:0]  rAdr[6] = '{A_RST, A_CFG, A_SEQ, A_TRIG, A_SPEC, 8'h00};
  logic [15:0] rVal[6] = '{16'h0000, 16'h8810, 16'h0080, 16'h0000,
                           16'h0000, 16'h0000};
  int          slotTbl[5] = '{20, 30, 60, 120, 30};

  initial begin
    {rst_n, wbCyc, wbStb, wbWe, sharedPin} = 5'h00;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatI = 32'h0000_0000;
    adcResult = 12'h400;
    ainThreshold = {16'hff00, 16'hff00};
    ainAction = 4'h0;
    {numErrors, checksDone, doneCnt, srCnt, reloadCnt} = '0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 6; i++)
      rd_chk(rAdr[i], rVal[i]);
    chk(32'(adcCfg), 32'h0000_8810);
    wr(A_CFG, 16'h0023);
    wr(A_RST, 16'h0012);
    rd_chk(A_CFG, 16'h0023);
    rd_chk(A_RST, 16'h0000);
    wr(A_SPEC, 16'h0004);
    wr(A_RST, 16'h00ad);
    repeat (2) @(posedge clk_sys);
    chk(32'(srCnt), 32'd1);
    chk(32'(reloadCnt), 32'd1);
    rd_chk(A_CFG, 16'h8810);
    rd_chk(A_SPEC, 16'h0000);
    wr(A_RST, 16'h00ad);
    repeat (2) @(posedge clk_sys);
    chk(32'(srCnt), 32'd2);
    chk(32'(reloadCnt), 32'd1);
    wr(A_TRIG, 16'h0002);
    repeat (2) @(posedge clk_sys);
    chk(32'(reloadCnt), 32'd2);
    rd_chk(A_TRIG, 16'h0000);
    // every combination of polarity bit, pin enable and pin level
    for (int i = 0; i < 8; i++) begin
      sharedPin <= i[0];
      wr(A_SPEC, {14'h0000, i[2], i[1]});
      repeat (4) @(posedge clk_sys);
      chk(32'(alarmLevel), 32'(i[2] | (i[0] & ~i[1])));
      chk(32'(pinAsInput), 32'(i[1]));
    end
    wr(A_SPEC, 16'h0000);
    run_pass(16'h8811, 8'h31, 1, '{4'h1, 4'h9, 4'h3});
    wr(A_SPEC, 16'h0001);
    run_pass(16'h8819, 8'h31, 3, '{4'h1, 4'h2, 4'h3});
    run_pass(16'h8811, 8'h25, 1, '{4'h5});
    run_pass(16'h8811, 8'h80, 1, '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                                  4'h6, 4'h7, 4'h8});
    // slot length per rate code, last entry an internal channel
    for (int r = 0; r < 5; r++) begin
      wr(A_CFG, 16'h8811 | 16'((r % 4) << 1));
      wr(A_SEQ, (r < 4) ? 16'h0011 : 16'h0044);
      wr(A_TRIG, 16'h0001);
      wait_done(n);
      chk(32'(n >= slotTbl[r] * TICK - 3 && n <= slotTbl[r] * TICK + 3), 1);
      wait_idle();
    end
    wr(A_CFG, 16'h8811);
    wr(A_SEQ, 16'h0080);
    doneCnt = 0;
    wr(A_TRIG, 16'h0001);
    repeat (10) @(posedge clk_sys);
    wr(A_TRIG, 16'h0000);
    repeat (2) @(posedge clk_sys);
    chk(32'(adcBusy), 32'd0);
    chk(32'(doneCnt), 32'd0);
    // auto mode with a two-fault trip on input zero
    wr(A_CFG, 16'h8830);
    wr(A_SEQ, 16'h0011);
    ainThreshold[0] <= 16'h8010;
    ainAction[0] <= 2'h2;
    adcResult <= 12'h900;
    wr(A_TRIG, 16'h0001);
    wait_done(n);
    repeat (2) @(posedge clk_sys);
    chk(32'(faultAlarm), 32'd0);
    chk(32'(driveLevel), 32'd0);
    wait_done(n);
    repeat (2) @(posedge clk_sys);
    chk(32'(faultAlarm), 32'd1);
    chk(32'(driveLevel), 32'd1);
    rd_chk(A_TRIG, 16'h0001);
    chk(32'(adcBusy), 32'd1);
    wr(A_TRIG, 16'h0000);
    repeat (2) @(posedge clk_sys);
    chk(32'(adcBusy), 32'd0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
